// >>> logic/rft_pkg.sv
// Package of constants for the RF event timer block
package rft_pkg;
    // Configuration word layout
    localparam int RFT_CFG_W = 10;
    localparam int RFT_BIT_RELOAD = 1;
    localparam int RFT_BIT_CLK_MODE = 2;
    localparam int RFT_PSC_LSB = 3;
    localparam int RFT_PSC_MSB = 5;
    localparam int RFT_BIT_START_NOW = 6;
    localparam int RFT_BIT_INT_OFF = 7;
    localparam int RFT_BIT_INT_ON = 8;
    localparam int RFT_BIT_EXT_LOST = 9;
    localparam logic [9:0] RFT_CFG_RESET = 10'h000;
    localparam logic [9:0] RFT_CFG_WR_MASK = 10'h3FE;
    // Preset and count width
    localparam int RFT_CNT_W = 16;
    localparam logic [15:0] RFT_CNT_ZERO = 16'h0000;
    localparam logic [15:0] RFT_CNT_ONE = 16'h0001;
    // Prescaler: code n divides the interface clock by 2^(n+1)
    localparam int RFT_PSC_W = 8;
    localparam logic [7:0] RFT_PSC_ZERO = 8'h00;
    localparam logic [7:0] RFT_PSC_ONE = 8'h01;
    localparam logic [7:0] RFT_PSC_BASE_MASK = 8'h01;
endpackage

// >>> logic/rft_rf_event_timer.sv
// Down-counting RF event timer with start events, prescaler and auto reload
`timescale 1ns/1ps
`default_nettype none

module rft_rf_event_timer
    import rft_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_contactless_interface_clock_tick,
    input wire logic i_cfg_write,
    input wire logic [RFT_CFG_W-1:0] i_cfg_data,
    input wire logic [RFT_CNT_W-1:0] i_preset_value,
    input wire logic i_internal_field_on,
    input wire logic i_external_field_detected,
    output logic [RFT_CFG_W-1:0] o_cfg_readback,
    output logic [RFT_CNT_W-1:0] o_timer_value,
    output logic o_timer_running,
    output logic o_timer_expired
);

    typedef struct packed {
        logic [RFT_CFG_W-1:0] cfg;
        logic [RFT_CNT_W-1:0] count;
        logic [RFT_PSC_W-1:0] psc;
        logic running;
        logic expired;
        logic int_m;
        logic int_s;
        logic int_d;
        logic ext_m;
        logic ext_s;
        logic ext_d;
    } rft_state_t;

    rft_state_t st_r;
    rft_state_t st_nxt;

    // Terminal mask of the prescaler counter for a rate code
    function automatic logic [RFT_PSC_W-1:0] rft_psc_mask(input logic [2:0] sel);
        logic [RFT_PSC_W-1:0] m;
        m = (RFT_PSC_BASE_MASK << sel) | ((RFT_PSC_BASE_MASK << sel) - RFT_PSC_ONE);
        return m;
    endfunction

    logic ev_int_on;
    logic ev_int_off;
    logic ev_ext_lost;
    logic start_now;
    logic start_any;
    logic psc_term;
    logic count_tick;
    logic at_expiry;

    // Edge detection works only on the second synchroniser stage and its delayed copy
    assign ev_int_on = st_r.int_s & ~st_r.int_d;
    assign ev_int_off = ~st_r.int_s & st_r.int_d;
    assign ev_ext_lost = ~st_r.ext_s & st_r.ext_d;
    assign start_now = i_cfg_write & i_cfg_data[RFT_BIT_START_NOW];
    // Any enabled source starts; the enables in force are those already stored
    assign start_any = start_now
        | (ev_int_on & st_r.cfg[RFT_BIT_INT_ON])
        | (ev_int_off & st_r.cfg[RFT_BIT_INT_OFF])
        | (ev_ext_lost & st_r.cfg[RFT_BIT_EXT_LOST]);
    // Prescaler terminal, bypassed entirely in direct clock mode
    assign psc_term = (st_r.psc & rft_psc_mask(st_r.cfg[RFT_PSC_MSB:RFT_PSC_LSB]))
        == rft_psc_mask(st_r.cfg[RFT_PSC_MSB:RFT_PSC_LSB]);
    assign count_tick = i_contactless_interface_clock_tick & (~st_r.cfg[RFT_BIT_CLK_MODE] | psc_term);
    // A preset of zero expires on the first tick rather than wrapping
    assign at_expiry = st_r.running & count_tick & (st_r.count <= RFT_CNT_ONE);

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.expired = 1'b0;
        st_nxt.int_m = i_internal_field_on;
        st_nxt.int_s = st_r.int_m;
        st_nxt.int_d = st_r.int_s;
        st_nxt.ext_m = i_external_field_detected;
        st_nxt.ext_s = st_r.ext_m;
        st_nxt.ext_d = st_r.ext_s;
        if (i_cfg_write) begin
            st_nxt.cfg = i_cfg_data & RFT_CFG_WR_MASK;
        end
        if (start_any) begin
            // A start while running restarts from the preset
            st_nxt.running = 1'b1;
            st_nxt.count = i_preset_value;
            st_nxt.psc = RFT_PSC_ZERO;
        end else if (st_r.running) begin
            if (i_contactless_interface_clock_tick & st_r.cfg[RFT_BIT_CLK_MODE]) begin
                st_nxt.psc = st_r.psc + RFT_PSC_ONE;
            end
            if (at_expiry) begin
                st_nxt.expired = 1'b1;
                if (st_r.cfg[RFT_BIT_RELOAD]) begin
                    st_nxt.count = i_preset_value;
                end else begin
                    st_nxt.count = RFT_CNT_ZERO;
                    st_nxt.running = 1'b0;
                end
            end else if (count_tick) begin
                st_nxt.count = st_r.count - RFT_CNT_ONE;
            end
        end
    end

    // State register; synchronous reset clears configuration and timer
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            st_r <= '0;
            // Synchronisers keep sampling the pins in reset, so a field already on at release
            // is not taken for a fresh edge that would start the timer falsely
            st_r.int_m <= st_nxt.int_m;
            st_r.int_s <= st_nxt.int_s;
            st_r.int_d <= st_nxt.int_d;
            st_r.ext_m <= st_nxt.ext_m;
            st_r.ext_s <= st_nxt.ext_s;
            st_r.ext_d <= st_nxt.ext_d;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_cfg_readback = st_r.cfg;
    assign o_timer_value = st_r.count;
    assign o_timer_running = st_r.running;
    assign o_timer_expired = st_r.expired;

    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    sequence s_started;
        st_r.running && (st_r.count == $past(i_preset_value)) && (st_r.psc == RFT_PSC_ZERO);
    endsequence

    sequence s_halted;
        !st_r.running && (st_r.count == RFT_CNT_ZERO);
    endsequence

    property p_start_now;
        i_cfg_write && i_cfg_data[RFT_BIT_START_NOW] |=> s_started;
    endproperty
    a_start_now: assert property (p_start_now) else $error("immediate start not taken");

    property p_int_on;
        ev_int_on && st_r.cfg[RFT_BIT_INT_ON] |=> s_started;
    endproperty
    a_int_on: assert property (p_int_on) else $error("field-on start not taken");

    property p_int_off;
        ev_int_off && st_r.cfg[RFT_BIT_INT_OFF] |=> s_started;
    endproperty
    a_int_off: assert property (p_int_off) else $error("field-off start not taken");

    property p_ext_lost;
        $fell(st_r.ext_s) && st_r.cfg[RFT_BIT_EXT_LOST] |=> s_started;
    endproperty
    a_ext_lost: assert property (p_ext_lost) else $error("external loss start not taken");

    property p_prescale_hold;
        st_r.running && st_r.cfg[RFT_BIT_CLK_MODE] && i_contactless_interface_clock_tick && !psc_term && !start_any
            |=> $stable(st_r.count);
    endproperty
    a_prescale_hold: assert property (p_prescale_hold) else $error("count moved between prescaler terminals");

    property p_direct_rate;
        st_r.running && !st_r.cfg[RFT_BIT_CLK_MODE] && i_contactless_interface_clock_tick && (st_r.count > RFT_CNT_ONE) && !start_any
            |=> st_r.count == $past(st_r.count) - RFT_CNT_ONE;
    endproperty
    a_direct_rate: assert property (p_direct_rate) else $error("direct mode did not count every tick");

    property p_prescaled_rate;
        st_r.running && st_r.cfg[RFT_BIT_CLK_MODE] && i_contactless_interface_clock_tick && psc_term && (st_r.count > RFT_CNT_ONE)
            && !start_any |=> st_r.count == $past(st_r.count) - RFT_CNT_ONE;
    endproperty
    a_prescaled_rate: assert property (p_prescaled_rate) else $error("prescaled terminal did not count");

    property p_stop;
        at_expiry && !st_r.cfg[RFT_BIT_RELOAD] && !start_any |=> s_halted ##0 st_r.expired;
    endproperty
    a_stop: assert property (p_stop) else $error("timer did not halt at expiry");

    property p_reload;
        at_expiry && st_r.cfg[RFT_BIT_RELOAD] && !start_any
            |=> st_r.running && st_r.expired && (st_r.count == $past(i_preset_value));
    endproperty
    a_reload: assert property (p_reload) else $error("timer did not reload at expiry");

    property p_cfg_reset;
        disable iff (1'b0) $past(i_sys_rst) && !i_sys_rst |-> (st_r.cfg == RFT_CFG_RESET) && !st_r.running;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("configuration not cleared by reset");

    property p_cfg_store;
        i_cfg_write |=> st_r.cfg == ($past(i_cfg_data) & RFT_CFG_WR_MASK);
    endproperty
    a_cfg_store: assert property (p_cfg_store) else $error("configuration write not stored");

    property p_halt_hold;
        !st_r.running && !start_any |=> !st_r.running && $stable(st_r.count);
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halted timer moved without a start");

    property p_any_start;
        start_any |=> st_r.running ##1 (st_r.running || st_r.expired || $past(at_expiry));
    endproperty
    a_any_start: assert property (p_any_start) else $error("enabled event did not start timer");

endmodule

`default_nettype wire

// >>> sim/rft_rf_event_timer_tb.sv
// Self-checking testbench for the RF event timer
`timescale 1ns/1ps
`default_nettype none
module rft_rf_event_timer_tb import rft_pkg::*; ();
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tick = 1'b0;
    logic wr = 1'b0;
    logic [RFT_CFG_W-1:0] cfg = 10'h000;
    logic [RFT_CNT_W-1:0] preset = 16'h0000;
    logic int_on = 1'b0;
    logic ext_det = 1'b0;
    logic [RFT_CFG_W-1:0] rdbk;
    logic [RFT_CNT_W-1:0] value;
    logic running;
    logic expired;
    int err_count = 0;
    int check_count = 0;

    rft_rf_event_timer i_rft_rf_event_timer (.i_clock(clk), .i_sys_rst(rst), .i_contactless_interface_clock_tick(tick),
        .i_cfg_write(wr), .i_cfg_data(cfg), .i_preset_value(preset), .i_internal_field_on(int_on),
        .i_external_field_detected(ext_det), .o_cfg_readback(rdbk), .o_timer_value(value),
        .o_timer_running(running), .o_timer_expired(expired));

    // 40 MHz clock; inputs move on the falling edge so the rising edge sees them settled
    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic do_reset();
        rst = 1'b1;
        cycles(12);
        rst = 1'b0;
    endtask
    // Leading idle cycle keeps each strobe from being assigned twice in one time step
    task automatic cfg_wr(input logic [9:0] d, input logic [15:0] p);
        cycles(1);
        wr = 1'b1;
        cfg = d;
        preset = p;
        cycles(1);
        wr = 1'b0;
    endtask
    // Back-to-back ticks; the expiry pulse is visible when this returns
    task automatic ticks(input int n);
        cycles(1);
        tick = 1'b1;
        cycles(n);
        tick = 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog sized well above the roughly 770 cycles the sequence needs
    initial begin
        #100000;
        err_count++;
        final_report();
    end

    initial begin
        do_reset();
        chk("cfg reset", 16'h0000, rdbk);
        chk("run reset", 16'h0000, running);
        cfg_wr(10'h3FF, 16'h0005);
        chk("cfg all", 16'h03FE, rdbk);
        chk("start now", 16'h0001, running);
        chk("start value", 16'h0005, value);
        // Mode 0 ignores the rate select and halts at zero without reload
        do_reset();
        cfg_wr(10'h078, 16'h0002);
        ticks(1);
        chk("direct rate", 16'h0001, value);
        ticks(1);
        chk("expiry pulse", 16'h0001, expired);
        chk("halt value", 16'h0000, value);
        chk("halt run", 16'h0000, running);
        ticks(3);
        chk("stay halted", 16'h0000, value);
        // Reload keeps counting from preset
        do_reset();
        cfg_wr(10'h042, 16'h0002);
        ticks(2);
        chk("reload pulse", 16'h0001, expired);
        chk("reload value", 16'h0002, value);
        chk("reload run", 16'h0001, running);
        ticks(1);
        chk("after reload", 16'h0001, value);
        // A start while running restarts from the new preset
        cfg_wr(10'h042, 16'h0004);
        chk("restart value", 16'h0004, value);
        // Every rate code divides the interface tick by 2^(code+1)
        for (int s = 0; s < 8; s++) begin
            do_reset();
            cfg_wr(10'h044 | 10'(s << 3), 16'h0003);
            ticks((2 << s) - 1);
            chk("psc hold", 16'h0003, value);
            ticks(1);
            chk("psc step", 16'h0002, value);
        end
        // Field events: internal on, internal off, external lost
        for (int i = 0; i < 3; i++) begin
            int_on = (i == 1);
            ext_det = (i == 2);
            do_reset();
            cfg_wr((i == 0) ? 10'h100 : (i == 1) ? 10'h080 : 10'h200, 16'h0007);
            chk("no start", 16'h0000, running);
            if (i == 2) begin
                ext_det = 1'b0;
            end else begin
                int_on = (i == 0);
            end
            cycles(1);
            chk("sync delay", 16'h0000, running);
            cycles(4);
            chk("event start", 16'h0001, running);
            chk("event value", 16'h0007, value);
        end
        // A field edge whose enable is clear must not start the timer
        int_on = 1'b0;
        ext_det = 1'b0;
        do_reset();
        cfg_wr(10'h280, 16'h0007);
        int_on = 1'b1;
        cycles(6);
        chk("disabled edge", 16'h0000, running);
        final_report();
    end
endmodule
`default_nettype wire
